// ---- src/ccpu_unit.sv ----
// Capture/compare/PWM unit with APB register access.
//
// Summary of operation
// R01 - 16-bit timer reloads value on every overflow
// R02 - 10-bit prescaler divides unit clock 1..1024
// R03 - Basic mode uses pclk, PWM modes use PLL
// R04 - PLL multiplies reference by 32
// R05 - Divider field N divides pclk by N+1
// R06 - Direction bit sets count; change reverses sequence
// R07 - Timer accessible anytime, writes applied coherently
// R08 - Every reload sets overflow flag
// R09 - Optional 8-bit counter width
// R10 - Enabled channel match sets compare flag
// R11 - Each compare output has selectable polarity
// R12 - Capture event copies timer into capture register
// R13 - Rising or falling edge per capture input
// R14 - Filter needs four equal samples first
// R15 - Event counter delays capture by N events
// R16 - Asymmetric PWM counts down ignoring direction
// R17 - Symmetric PWM counts up then down
// R18 - Pin holds level until compare event
// R19 - Alternating pairs A/B, C/D gated each cycle
// R20 - Seven interrupt sources share one request
// R21 - Flags sticky; request ORs enabled flags
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_defs.svh"
module ccpu_unit
  import ccpu_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins.
  input wire logic [1:0] cap_in,
  output logic [3:0] pwm_out,
  output logic irq
);

  // ************************************************************
  // Register file.
  // ************************************************************
  ccpu_ctrl_t ctrl_reg;
  ccpu_chcfg_t chcfg_reg;
  ccpu_capcfg_t capcfg_reg;
  logic [9:0] psc_reload_reg;
  logic [15:0] reload_reg;
  logic [15:0] cmp_reg [4];
  logic [15:0] cap_reg [2];
  logic [6:0] flags_reg;
  logic [6:0] ien_reg;
  logic [3:0] pll_divider_field_reg;
  logic [15:0] tmr_reg;
  logic [15:0] tmr_shadow_reg;
  logic tmr_wr_pend_reg;
  logic pll_lock_reg;
  logic [6:0] flag_set;
  logic wr_en;
  logic setup;
  logic mapped;
  logic [31:0] rd_mux;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready && pwrite;

  always_comb
  begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      `CCPU_OFS_CTRL:
      begin
        rd_mux[6:0] = ctrl_reg;
        rd_mux[`CCPU_CTRL_LOCK_BIT] = pll_lock_reg;
      end
      `CCPU_OFS_PRESCALE: rd_mux[9:0] = psc_reload_reg;
      `CCPU_OFS_RELOAD: rd_mux[15:0] = reload_reg;
      `CCPU_OFS_TIMER: rd_mux[15:0] = tmr_reg;
      `CCPU_OFS_CHCFG: rd_mux[11:0] = chcfg_reg;
      `CCPU_OFS_CMP0: rd_mux[15:0] = cmp_reg[0];
      `CCPU_OFS_CMP0 + 8'h04: rd_mux[15:0] = cmp_reg[1];
      `CCPU_OFS_CMP0 + 8'h08: rd_mux[15:0] = cmp_reg[2];
      `CCPU_OFS_CMP0 + 8'h0C: rd_mux[15:0] = cmp_reg[3];
      `CCPU_OFS_CAPCFG: rd_mux[11:0] = capcfg_reg;
      `CCPU_OFS_CAP0: rd_mux[15:0] = cap_reg[0];
      `CCPU_OFS_CAP1: rd_mux[15:0] = cap_reg[1];
      `CCPU_OFS_FLAGS: rd_mux[6:0] = flags_reg;
      `CCPU_OFS_IEN: rd_mux[6:0] = ien_reg;
      `CCPU_OFS_PLLDIV: rd_mux[3:0] = pll_divider_field_reg;
      default: mapped = 1'b0;
    endcase
  end

  // Zero-wait slave: answer is registered during the setup cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite)
        prdata <= rd_mux;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= '0;
      chcfg_reg <= '0;
      capcfg_reg <= '0;
      psc_reload_reg <= `CCPU_RST_PSC;
      reload_reg <= `CCPU_RST_RELOAD;
      cmp_reg <= '{default: 16'h0000};
      ien_reg <= 7'h00;
      pll_divider_field_reg <= 4'h0;
    end
    else if (wr_en)
    begin
      unique case (paddr)
        `CCPU_OFS_CTRL: ctrl_reg <= ccpu_ctrl_t'(pwdata[6:0]);
        `CCPU_OFS_PRESCALE: psc_reload_reg <= pwdata[9:0];
        `CCPU_OFS_RELOAD: reload_reg <= pwdata[15:0];
        `CCPU_OFS_CHCFG: chcfg_reg <= ccpu_chcfg_t'(pwdata[11:0]);
        `CCPU_OFS_CMP0: cmp_reg[0] <= pwdata[15:0];
        `CCPU_OFS_CMP0 + 8'h04: cmp_reg[1] <= pwdata[15:0];
        `CCPU_OFS_CMP0 + 8'h08: cmp_reg[2] <= pwdata[15:0];
        `CCPU_OFS_CMP0 + 8'h0C: cmp_reg[3] <= pwdata[15:0];
        `CCPU_OFS_CAPCFG: capcfg_reg <= ccpu_capcfg_t'(pwdata[11:0]);
        `CCPU_OFS_IEN: ien_reg <= pwdata[6:0];
        `CCPU_OFS_PLLDIV: pll_divider_field_reg <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky flags: write one to clear, a same-cycle set wins.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags_reg <= 7'h00;
    else if (wr_en && paddr == `CCPU_OFS_FLAGS)
      flags_reg <= (flags_reg & ~pwdata[6:0]) | flag_set; // R21
    else
      flags_reg <= flags_reg | flag_set; // R08
  end

  // One shared request for all seven sources.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flags_reg & ien_reg); // R20 R21
  end

  // ************************************************************
  // Clock selection, PLL reference divider and prescaler.
  // ************************************************************
  logic [3:0] pll_div_cnt_reg;
  logic [1:0] pll_refs_reg;
  logic pll_ref;
  logic [9:0] psc_cnt_reg;
  logic unit_clock;
  logic tick;

  assign pll_ref = pll_div_cnt_reg == pll_divider_field_reg;

  // The multiplied PLL rate is never below pclk, so lock gates the PWM clock.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pll_div_cnt_reg <= 4'h0;
      pll_refs_reg <= 2'h0;
      pll_lock_reg <= 1'b0;
    end
    else
    begin
      pll_div_cnt_reg <= pll_ref ? 4'h0 : 4'(pll_div_cnt_reg + 4'h1); // R05
      if (ctrl_reg.mode == CCPU_BASIC)
      begin
        pll_refs_reg <= 2'h0;
        pll_lock_reg <= 1'b0;
      end
      else if (pll_ref && !pll_lock_reg)
      begin
        pll_refs_reg <= 2'(pll_refs_reg + 2'h1);
        pll_lock_reg <= pll_refs_reg == `CCPU_PLL_LOCK_REFS - 2'h1; // R04
      end
    end
  end

  assign unit_clock = (ctrl_reg.mode == CCPU_BASIC) || pll_lock_reg; // R03
  assign tick = unit_clock && ctrl_reg.run && psc_cnt_reg == `CCPU_PSC_TOP;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      psc_cnt_reg <= `CCPU_RST_PSC;
    else if (unit_clock && ctrl_reg.run)
      psc_cnt_reg <= tick ? psc_reload_reg : 10'(psc_cnt_reg + 10'h001); // R02
  end

  // ************************************************************
  // Timer.
  // ************************************************************
  logic [15:0] top;
  logic [15:0] rld;
  logic [15:0] tmr_next;
  logic sym_up_reg;
  logic sym_up_next;
  logic reload_evt;
  logic counting_up;

  assign top = ctrl_reg.eight_bit ? `CCPU_TOP8 : `CCPU_TOP16; // R09
  assign rld = reload_reg & top;

  always_comb
  begin
    tmr_next = tmr_reg;
    sym_up_next = sym_up_reg;
    reload_evt = 1'b0;
    counting_up = 1'b0;
    if (tick)
    begin
      unique case (ctrl_reg.mode)
        CCPU_SYM:
        begin
          counting_up = sym_up_reg;
          if (sym_up_reg && tmr_reg >= rld)
          begin
            sym_up_next = 1'b0; // R17
            tmr_next = 16'(tmr_reg - 16'h0001);
          end
          else if (sym_up_reg)
            tmr_next = 16'(tmr_reg + 16'h0001);
          else if (tmr_reg == 16'h0000)
          begin
            sym_up_next = 1'b1; // R17
            reload_evt = 1'b1;
            tmr_next = 16'h0001;
          end
          else
            tmr_next = 16'(tmr_reg - 16'h0001);
        end
        CCPU_ASYM:
        begin
          reload_evt = tmr_reg == 16'h0000; // R16
          tmr_next = reload_evt ? rld : 16'(tmr_reg - 16'h0001);
        end
        default:
        begin
          counting_up = !ctrl_reg.dir_down; // R06
          if (counting_up)
          begin
            reload_evt = tmr_reg == top; // R01
            tmr_next = reload_evt ? rld : 16'(tmr_reg + 16'h0001);
          end
          else
          begin
            reload_evt = tmr_reg == 16'h0000;
            tmr_next = reload_evt ? rld : 16'(tmr_reg - 16'h0001);
          end
        end
      endcase
    end
  end

  // A bus write lands in the shadow and is applied whole on the next edge.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tmr_reg <= 16'h0000;
      tmr_shadow_reg <= 16'h0000;
      tmr_wr_pend_reg <= 1'b0;
      sym_up_reg <= 1'b1;
    end
    else
    begin
      tmr_wr_pend_reg <= wr_en && paddr == `CCPU_OFS_TIMER;
      if (wr_en && paddr == `CCPU_OFS_TIMER)
        tmr_shadow_reg <= pwdata[15:0]; // R07
      tmr_reg <= (tmr_wr_pend_reg ? tmr_shadow_reg : tmr_next) & top; // R07
      sym_up_reg <= ctrl_reg.mode == CCPU_SYM ? sym_up_next : 1'b1;
    end
  end

  // ************************************************************
  // Compare channels and PWM outputs.
  // ************************************************************
  logic [3:0] match;
  logic [3:0] cmp_state_reg;
  logic phase_reg;
  logic asym;

  assign asym = ctrl_reg.mode == CCPU_ASYM;

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      match[i] = tick && chcfg_reg.en[i] && tmr_reg == cmp_reg[i]; // R10
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmp_state_reg <= 4'h0;
      phase_reg <= 1'b0;
    end
    else
    begin
      if (reload_evt && asym)
        phase_reg <= !phase_reg; // R19
      for (int i = 0; i < 4; i++)
      begin
        if (!chcfg_reg.en[i])
          cmp_state_reg[i] <= chcfg_reg.halt_level[i]; // R18
        else if (ctrl_reg.mode == CCPU_BASIC)
        begin
          if (match[i])
            cmp_state_reg[i] <= !cmp_state_reg[i]; // R18
        end
        else if (ctrl_reg.mode == CCPU_SYM)
        begin
          if (match[i])
            cmp_state_reg[i] <= counting_up; // R17
        end
        else if (match[i])
          cmp_state_reg[i] <= 1'b1;
        else if (reload_evt)
          cmp_state_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pwm_out <= 4'h0;
    else
    begin
      for (int i = 0; i < 4; i++)
      begin
        if (asym && (i < 2 ? ctrl_reg.alt_ab : ctrl_reg.alt_cd)
            && (phase_reg ^ i[0]))
          pwm_out[i] <= chcfg_reg.pol[i]; // R19
        else
          pwm_out[i] <= cmp_state_reg[i] ^ chcfg_reg.pol[i]; // R11
      end
    end
  end

  // ************************************************************
  // Capture inputs.
  // ************************************************************
  logic [3:0] samp_reg [2];
  logic [1:0] level_reg;
  logic [1:0] edge_evt;
  logic [1:0] cap_evt;
  logic [3:0] ev_cnt_reg [2];
  logic [3:0] ev_cfg [2];

  assign ev_cfg[0] = capcfg_reg.evcnt0;
  assign ev_cfg[1] = capcfg_reg.evcnt1;

  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (capcfg_reg.filt[i])
        edge_evt[i] = (samp_reg[i] == {4{!level_reg[i]}}); // R14
      else
        edge_evt[i] = samp_reg[i][0] != level_reg[i];
      edge_evt[i] = edge_evt[i] && (level_reg[i] == capcfg_reg.fall[i]); // R13
      cap_evt[i] = edge_evt[i] && ev_cnt_reg[i] == ev_cfg[i]; // R15
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      samp_reg <= '{default: 4'h0};
      level_reg <= 2'b00;
      ev_cnt_reg <= '{default: 4'h0};
      cap_reg <= '{default: 16'h0000};
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        samp_reg[i] <= {samp_reg[i][2:0], cap_in[i]};
        if (capcfg_reg.filt[i] ? samp_reg[i] == {4{!level_reg[i]}}
            : samp_reg[i][0] != level_reg[i])
          level_reg[i] <= !level_reg[i];
        if (cap_evt[i])
        begin
          ev_cnt_reg[i] <= 4'h0;
          cap_reg[i] <= tmr_reg; // R12
        end
        else if (edge_evt[i])
          ev_cnt_reg[i] <= 4'(ev_cnt_reg[i] + 4'h1); // R15
      end
    end
  end

  assign flag_set = {match, cap_evt, reload_evt}; // R20

  // ************************************************************
  // Checks.
  // ************************************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ovf_flag: assert property (reload_evt |=> flags_reg[`CCPU_FLAG_OVF]) // R08
    else $error("Reload did not set the overflow flag.");
  chk_irq_enabled: assert property (|(flags_reg & ien_reg) |=> irq) // R21
    else $error("Enabled flag did not raise the request.");
  chk_cap_copy: assert property (cap_evt[0] |=> cap_reg[0] == $past(tmr_reg)) // R12
    else $error("Capture register did not take the timer value.");
  chk_asym_down: assert property (asym && tick && !tmr_wr_pend_reg && tmr_reg != 16'h0000
    |=> tmr_reg == 16'($past(tmr_reg) - 16'h0001)) // R16
    else $error("Asymmetric timer did not count down.");
  chk_dir_down: assert property (ctrl_reg.mode == CCPU_BASIC && ctrl_reg.dir_down && tick
    && !tmr_wr_pend_reg && tmr_reg != 16'h0000 |=> tmr_reg < $past(tmr_reg)) // R06
    else $error("Down direction did not decrement.");
  chk_psc_reload: assert property (tick |=> psc_cnt_reg == $past(psc_reload_reg)) // R02
    else $error("Prescaler did not reload.");
  chk_filter_four: assert property (capcfg_reg.filt[0] && edge_evt[0]
    |-> $past(cap_in[0], 4) == $past(cap_in[0], 1)) // R14
    else $error("Filtered edge seen without four equal samples.");
  chk_cmp_flag: assert property (match[1] |=> flags_reg[`CCPU_FLAG_CMP0 + 1]) // R10
    else $error("Compare match did not set its flag.");
  chk_halt_level: assert property (!chcfg_reg.en[2] ##1 !chcfg_reg.en[2]
    |-> cmp_state_reg[2] == $past(chcfg_reg.halt_level[2])) // R18
    else $error("Disabled channel left its halt level.");
  chk_eight_bit: assert property (ctrl_reg.eight_bit ##1 ctrl_reg.eight_bit
    |-> tmr_reg[15:8] == 8'h00) // R09
    else $error("Eight-bit timer used its upper byte.");

endmodule : ccpu_unit
`default_nettype wire

// ---- shared/ccpu_defs.svh ----
// Register offsets, field positions and reset values of the capture/compare/PWM unit.
`ifndef CCPU_DEFS_SVH
`define CCPU_DEFS_SVH
`define CCPU_OFS_CTRL 8'h00
`define CCPU_OFS_PRESCALE 8'h04
`define CCPU_OFS_RELOAD 8'h08
`define CCPU_OFS_TIMER 8'h0C
`define CCPU_OFS_CHCFG 8'h10
`define CCPU_OFS_CMP0 8'h14
`define CCPU_OFS_CAPCFG 8'h24
`define CCPU_OFS_CAP0 8'h28
`define CCPU_OFS_CAP1 8'h2C
`define CCPU_OFS_FLAGS 8'h30
`define CCPU_OFS_IEN 8'h34
`define CCPU_OFS_PLLDIV 8'h38
`define CCPU_CTRL_LOCK_BIT 8
`define CCPU_FLAG_OVF 0
`define CCPU_FLAG_CAP0 1
`define CCPU_FLAG_CMP0 3
`define CCPU_TOP16 16'hFFFF
`define CCPU_TOP8 16'h00FF
`define CCPU_PSC_TOP 10'h3FF
`define CCPU_RST_PSC 10'h3FF
`define CCPU_RST_RELOAD 16'h0000
`define CCPU_PLL_LOCK_REFS 2'h2
`endif

// ---- shared/ccpu_pkg.sv ----
// Types shared by the capture/compare/PWM unit.
package ccpu_pkg;
  typedef enum logic [1:0] {
    CCPU_BASIC = 2'b00,
    CCPU_ASYM = 2'b01,
    CCPU_SYM = 2'b10
  } ccpu_mode_t;
  typedef struct packed {
    logic alt_cd;
    logic alt_ab;
    logic eight_bit;
    logic dir_down;
    ccpu_mode_t mode;
    logic run;
  } ccpu_ctrl_t;
  typedef struct packed {
    logic [3:0] halt_level;
    logic [3:0] pol;
    logic [3:0] en;
  } ccpu_chcfg_t;
  typedef struct packed {
    logic [3:0] evcnt1;
    logic [3:0] evcnt0;
    logic [1:0] filt;
    logic [1:0] fall;
  } ccpu_capcfg_t;
endpackage : ccpu_pkg

// ---- sim/ccpu_far_model.sv ----
// Far-side model: capture signal sources and a PWM load that counts the edges of channel A.
`timescale 1ns/1ps
`default_nettype none
module ccpu_far_model
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Capture sources.
  output logic [1:0] cap_in,
  // PWM load.
  input wire logic [3:0] pwm_out,
  output logic [7:0] pwm0_edges
);
  logic pwm0_last;

  initial cap_in = 2'h0;

  // ****************************************
  // Load side: every level change of channel A is counted.
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pwm0_last <= 1'h0;
      pwm0_edges <= 8'h00;
    end
    else
    begin
      pwm0_last <= pwm_out[0];
      if (pwm_out[0] != pwm0_last)
      begin
        pwm0_edges <= pwm0_edges + 8'h01;
      end
    end
  end

  // Drives one capture line just after an edge and holds it for the given cycles.
  task automatic set_level(input int ch, input logic lvl, input int cycles);
    @(posedge pclk);
    cap_in[ch] <= lvl;
    repeat (cycles) @(posedge pclk);
  endtask : set_level
endmodule : ccpu_far_model
`default_nettype wire

// ---- sim/ccpu_unit_tb.sv ----
// Self-checking bench of the capture/compare/PWM unit.
`timescale 1ns/1ps
`default_nettype none
`include "ccpu_defs.svh"
module ccpu_unit_tb;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic irq;
  logic [1:0] cap_in;
  logic [3:0] pwm_out;
  logic [7:0] pwm0_edges;
  logic [31:0] rdat;
  logic rerr;
  int errors = 0;
  int total_checks = 0;
  int cycles = 0;

  always #10 pclk = ~pclk;

  ccpu_unit u_ccpu_unit (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cap_in(cap_in), .pwm_out(pwm_out), .irq(irq));

  ccpu_far_model u_ccpu_far_model (.pclk(pclk), .presetn(presetn), .cap_in(cap_in),
    .pwm_out(pwm_out), .pwm0_edges(pwm0_edges));

  // ****************************************
  // Verdict, timeout, bus and compare tasks.
  // ****************************************
  task automatic close_out();
    if (errors == 0 && total_checks > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      close_out();
    end
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; the request stands until pready is sampled high, or for at most 16 cycles.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1)
    begin
      chk("pready", 32'h1, {31'h0, pready});
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
    input string what);
    apb(1'h0, a, 32'h0);
    chk(what, e, rdat & m);
  endtask : rdc

  // ****************************************
  // Scenarios.
  // ****************************************
  task automatic t_reset();
    rdc(`CCPU_OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl");
    rdc(`CCPU_OFS_PRESCALE, 32'hFFFFFFFF, 32'h3FF, "prescale");
    rdc(`CCPU_OFS_RELOAD, 32'hFFFFFFFF, 32'h0, "reload");
    rdc(`CCPU_OFS_FLAGS, 32'hFFFFFFFF, 32'h0, "flags");
    wr(8'h3C, 32'hFFFF);
    apb(1'h0, 8'h3C, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, rerr});
    chk("unmapped data", 32'h0, rdat);
    wr(`CCPU_OFS_TIMER, 32'h1234);
    rdc(`CCPU_OFS_TIMER, 32'hFFFFFFFF, 32'h1234, "timer");
  endtask : t_reset

  task automatic t_pll();
    wr(`CCPU_OFS_PLLDIV, 32'hF);
    wr(`CCPU_OFS_CTRL, 32'h2);
    rdc(`CCPU_OFS_CTRL, 32'h100, 32'h0, "lock early");
    repeat (40) @(posedge pclk);
    rdc(`CCPU_OFS_CTRL, 32'h100, 32'h100, "lock late");
    wr(`CCPU_OFS_PLLDIV, 32'h0);
    wr(`CCPU_OFS_RELOAD, 32'h8);
  endtask : t_pll

  // Runs the timer for a while from a known value and judges the overflow flag.
  task automatic run_case(input logic [9:0] psc, input logic [6:0] ctrl,
    input logic [15:0] tmr, input int cyc, input logic exp);
    wr(`CCPU_OFS_CTRL, 32'h0);
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_PRESCALE, {22'h0, psc});
    wr(`CCPU_OFS_TIMER, {16'h0, tmr});
    wr(`CCPU_OFS_CTRL, {25'h0, ctrl});
    repeat (cyc) @(posedge pclk);
    wr(`CCPU_OFS_CTRL, {25'h0, ctrl} & 32'h7E);
    rdc(`CCPU_OFS_FLAGS, 32'h1, {31'h0, exp}, "overflow flag");
  endtask : run_case

  task automatic t_count();
    run_case(10'h3FF, 7'h11, 16'h00F0, 40, 1'h1);
    run_case(10'h3FF, 7'h01, 16'h00F0, 40, 1'h0);
    run_case(10'h3FF, 7'h01, 16'hFFF0, 40, 1'h1);
    run_case(10'h3FF, 7'h09, 16'h0010, 40, 1'h1);
    run_case(10'h3FF, 7'h03, 16'h0010, 40, 1'h1);
    run_case(10'h3FF, 7'h05, 16'h0004, 40, 1'h1);
    run_case(10'h3F0, 7'h11, 16'h00FE, 8, 1'h0);
    run_case(10'h3F0, 7'h11, 16'h00FE, 48, 1'h1);
  endtask : t_count

  task automatic t_compare();
    wr(`CCPU_OFS_CTRL, 32'h0);
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_PRESCALE, 32'h3FF);
    wr(`CCPU_OFS_CMP0, 32'h10);
    wr(`CCPU_OFS_CMP0 + 8'h04, 32'h10);
    wr(`CCPU_OFS_TIMER, 32'h8);
    wr(`CCPU_OFS_CHCFG, 32'h841);
    repeat (4) @(posedge pclk);
    chk("pwm idle", 32'hC, {28'h0, pwm_out});
    chk("pwm edges idle", 32'h0, {24'h0, pwm0_edges});
    wr(`CCPU_OFS_CTRL, 32'h1);
    repeat (30) @(posedge pclk);
    wr(`CCPU_OFS_CTRL, 32'h0);
    rdc(`CCPU_OFS_FLAGS, 32'h78, 32'h08, "compare flags");
    chk("pwm match", 32'hD, {28'h0, pwm_out});
    chk("pwm edges", 32'h1, {24'h0, pwm0_edges});
  endtask : t_compare

  task automatic t_irq();
    wr(`CCPU_OFS_IEN, 32'h01);
    repeat (4) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(`CCPU_OFS_IEN, 32'h08);
    repeat (4) @(posedge pclk);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(`CCPU_OFS_FLAGS, 32'h01);
    rdc(`CCPU_OFS_FLAGS, 32'h08, 32'h08, "flag sticky");
    wr(`CCPU_OFS_FLAGS, 32'h08);
    repeat (4) @(posedge pclk);
    chk("irq clear", 32'h0, {31'h0, irq});
    wr(`CCPU_OFS_IEN, 32'h0);
  endtask : t_irq

  // Alternating pair in asymmetric mode: A and B take turns and never drive together.
  task automatic t_alt();
    int both;
    int seen_a;
    int seen_b;
    both = 0;
    seen_a = 0;
    seen_b = 0;
    wr(`CCPU_OFS_CTRL, 32'h0);
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_CMP0, 32'h4);
    wr(`CCPU_OFS_CMP0 + 8'h04, 32'h4);
    wr(`CCPU_OFS_TIMER, 32'h8);
    wr(`CCPU_OFS_CHCFG, 32'h003);
    wr(`CCPU_OFS_CTRL, 32'h23);
    repeat (40)
    begin
      @(posedge pclk);
      both += (pwm_out[1:0] == 2'h3);
      seen_a += pwm_out[0];
      seen_b += pwm_out[1];
    end
    wr(`CCPU_OFS_CTRL, 32'h0);
    chk("alt overlap", 32'h0, both);
    chk("alt a active", 32'h1, {31'h0, seen_a > 0});
    chk("alt b active", 32'h1, {31'h0, seen_b > 0});
    rdc(`CCPU_OFS_FLAGS, 32'h18, 32'h18, "pair flags");
  endtask : t_alt

  task automatic t_capture();
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_CAPCFG, 32'h002);
    wr(`CCPU_OFS_TIMER, 32'h0555);
    u_ccpu_far_model.set_level(0, 1'h1, 6);
    u_ccpu_far_model.set_level(1, 1'h1, 6);
    rdc(`CCPU_OFS_CAP0, 32'hFFFF, 32'h0555, "cap0");
    rdc(`CCPU_OFS_FLAGS, 32'h6, 32'h2, "cap flags rise");
    wr(`CCPU_OFS_TIMER, 32'h0AAA);
    u_ccpu_far_model.set_level(0, 1'h0, 6);
    u_ccpu_far_model.set_level(1, 1'h0, 6);
    rdc(`CCPU_OFS_CAP1, 32'hFFFF, 32'h0AAA, "cap1");
    rdc(`CCPU_OFS_CAP0, 32'hFFFF, 32'h0555, "cap0 fall");
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_CAPCFG, 32'h004);
    u_ccpu_far_model.set_level(0, 1'h1, 1);
    u_ccpu_far_model.set_level(0, 1'h0, 8);
    rdc(`CCPU_OFS_FLAGS, 32'h2, 32'h0, "filter glitch");
    u_ccpu_far_model.set_level(0, 1'h1, 8);
    rdc(`CCPU_OFS_FLAGS, 32'h2, 32'h2, "filter edge");
    u_ccpu_far_model.set_level(0, 1'h0, 8);
  endtask : t_capture

  task automatic t_events();
    wr(`CCPU_OFS_FLAGS, 32'h7F);
    wr(`CCPU_OFS_CAPCFG, 32'h020);
    for (int i = 0; i < 2; i++)
    begin
      u_ccpu_far_model.set_level(0, 1'h1, 4);
      u_ccpu_far_model.set_level(0, 1'h0, 4);
    end
    rdc(`CCPU_OFS_FLAGS, 32'h2, 32'h0, "events two");
    u_ccpu_far_model.set_level(0, 1'h1, 4);
    u_ccpu_far_model.set_level(0, 1'h0, 4);
    rdc(`CCPU_OFS_FLAGS, 32'h2, 32'h2, "events three");
  endtask : t_events

  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'h1;
    t_reset();
    t_pll();
    t_count();
    t_compare();
    t_irq();
    t_alt();
    t_capture();
    t_events();
    close_out();
  end
endmodule : ccpu_unit_tb
`default_nettype wire
